//--- hw/ucf_pkg.sv
package ucf_pkg;
   // register indices (word addresses on the plain port)
   localparam logic [3:0] UCF_ADDR_CTRL3 = 4'h0;   // usart_control_three
   localparam logic [3:0] UCF_ADDR_GUARD_TIME_AND_DIVIDER  = 4'h1;   // guard_time_and_divider
   localparam logic [3:0] UCF_ADDR_STAT  = 4'h2;   // sticky event status, read only
   localparam logic [3:0] UCF_ADDR_CLR   = 4'h3;   // write one to clear status
   localparam logic [3:0] UCF_ADDR_IEN   = 4'h4;   // status interrupt enable
   // control word field positions
   localparam int UCF_B_ERROR_IRQ_ENABLE  = 0;
   localparam int UCF_B_IREN    = 1;
   localparam int UCF_B_IRLP    = 2;
   localparam int UCF_B_SWIRE   = 3;
   localparam int UCF_B_NACK    = 4;
   localparam int UCF_B_SCEN    = 5;
   localparam int UCF_B_RXDMA   = 6;
   localparam int UCF_B_TXDMA   = 7;
   localparam int UCF_B_RTS_FLOW_ENABLE   = 8;
   localparam int UCF_B_CTS_FLOW_ENABLE   = 9;
   localparam int UCF_B_CTSIEN  = 10;
   localparam int UCF_CTRL3_W   = 11;               // bits 31:11 read zero
   localparam int UCF_GUARD_TIME_AND_DIVIDER_W    = 16;               // bits 31:16 read zero
   localparam logic [10:0] UCF_CTRL3_RST = 11'h000;
   localparam logic [15:0] UCF_GUARD_TIME_AND_DIVIDER_RST  = 16'h0000;
   // status bit positions
   localparam int UCF_S_ERR  = 0;
   localparam int UCF_S_CTS  = 1;
   localparam int UCF_S_TC   = 2;
   localparam int UCF_STAT_W = 3;
   // event inputs from the frame engine
   typedef struct packed {
      logic frame_err;
      logic overflow_err;
      logic noise_err;
      logic parity_err;
      logic cts_change;
      logic tx_char_done;
      logic tx_empty;
      logic rx_full;
   } ucf_evt_t;
   // decoded mode outputs
   typedef struct packed {
      logic cts_flow;
      logic rts_flow;
      logic smartcard;
      logic single_wire;
      logic infrared;
      logic ir_low_power;
   } ucf_mode_t;
endpackage

//--- hw/ucf_top.sv
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Function
// RL1: reserved upper bits of both words read zero
// RL2: cts, rts, cts-change irq enables reset clear
// RL3: tx dma requests only when enabled
// RL4: rx dma requests only when enabled
// RL5: smartcard enable selects smartcard operation
// RL6: parity error sends nack when enabled
// RL7: half duplex shares one line
// RL8: low power selects low-power infrared encoding
// RL9: infrared enable routes data through encoder
// RL10: error interrupt on frame, overflow, noise
// RL11: smartcard delays complete flag by guard time
// RL12: software sets divider one in normal infrared
// RL13: low power divides clock by divider value
// RL14: code one divides one, two divides two
// RL15: smartcard clock divides by twice low five bits
// RL16: software never writes smartcard divider zero
// RL17: all enables and dividers reset to zero
module ucf_top
   import ucf_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire ucf_evt_t    i_evt,
   output logic [31:0]      o_rdata,
   output ucf_mode_t        o_mode,
   output logic             o_tx_dma_req,
   output logic             o_rx_dma_req,
   output logic             o_nack_req,
   output logic             o_tx_complete,
   output logic             o_ir_tick,
   output logic             o_card_clk,
   output logic             o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // register storage
   logic [UCF_CTRL3_W-1:0] ctrl_q;       // usart_control_three live bits
   logic [UCF_GUARD_TIME_AND_DIVIDER_W-1:0]  guard_time_and_divider_q;       // guard_time_and_divider live bits
   logic [UCF_STAT_W-1:0]  stat_q;       // sticky events
   logic [UCF_STAT_W-1:0]  ien_q;        // event interrupt enables
   logic [31:0]            rdata_q;      // read data register

   // decodes
   wire wr_ctrl = i_wr && (i_addr == UCF_ADDR_CTRL3);
   wire wr_guard_time_and_divider = i_wr && (i_addr == UCF_ADDR_GUARD_TIME_AND_DIVIDER);
   wire wr_clr  = i_wr && (i_addr == UCF_ADDR_CLR);
   wire wr_ien  = i_wr && (i_addr == UCF_ADDR_IEN);

   // named control fields
   wire       sc_en    = ctrl_q[UCF_B_SCEN];
   wire       ir_en    = ctrl_q[UCF_B_IREN];
   wire       ir_lp    = ctrl_q[UCF_B_IRLP];
   wire [7:0] guard    = guard_time_and_divider_q[15:8];      // card_guard_time
   wire [7:0] divider  = guard_time_and_divider_q[7:0];       // infrared_card_divider
   wire [4:0] card_div = divider[4:0];      // only low five used in smartcard

   ////////////////////////////////////////////////////////////////////////
   // configuration words; reserved bits are simply not stored
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= UCF_CTRL3_RST;              // RL17 RL2
         guard_time_and_divider_q <= UCF_GUARD_TIME_AND_DIVIDER_RST;               // RL17
         ien_q  <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_wdata[UCF_CTRL3_W-1:0]; // RL1
         end
         if (wr_guard_time_and_divider) begin
            guard_time_and_divider_q <= i_wdata[UCF_GUARD_TIME_AND_DIVIDER_W-1:0];  // RL1
         end
         if (wr_ien) begin
            ien_q <= i_wdata[UCF_STAT_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses and write-only clear read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_addr)
         UCF_ADDR_CTRL3: rd_mux = {21'h000000, ctrl_q};   // RL1
         UCF_ADDR_GUARD_TIME_AND_DIVIDER:  rd_mux = {16'h0000, guard_time_and_divider_q};     // RL1
         UCF_ADDR_STAT:  rd_mux = {29'h0, stat_q};
         UCF_ADDR_IEN:   rd_mux = {29'h0, ien_q};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= i_rd ? rd_mux : 32'h0000_0000;   // valid one cycle only
      end
   end
   assign o_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // guard time: in smartcard mode the complete flag waits guard bit times,
   // counted here in peripheral clocks since the bit clock lives elsewhere
   logic [7:0] gt_cnt_q;
   logic       gt_run_q;
   logic       tc_q;
   wire        gt_done = gt_run_q && (gt_cnt_q == 8'h00);
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         gt_cnt_q <= 8'h00;
         gt_run_q <= 1'b0;
         tc_q     <= 1'b0;
      end else begin
         tc_q <= 1'b0;
         if (i_evt.tx_char_done) begin
            if (sc_en && guard != 8'h00) begin
               gt_run_q <= 1'b1;                   // RL11
               gt_cnt_q <= guard - 8'h01;
            end else begin
               tc_q <= 1'b1;
            end
         end else if (gt_run_q) begin
            if (gt_done) begin
               gt_run_q <= 1'b0;
               tc_q     <= 1'b1;                   // RL11
            end else begin
               gt_cnt_q <= gt_cnt_q - 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status; set wins over a simultaneous clear
   wire any_err = i_evt.frame_err | i_evt.overflow_err | i_evt.noise_err;
   wire [UCF_STAT_W-1:0] set_v = {tc_q, i_evt.cts_change, any_err};
   wire [UCF_STAT_W-1:0] clr_v = wr_clr ? i_wdata[UCF_STAT_W-1:0] : '0;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~clr_v) | set_v;
      end
   end

   // error and cts-change also honour their own control-word enables
   wire irq_d = (stat_q[UCF_S_ERR] & ien_q[UCF_S_ERR] & ctrl_q[UCF_B_ERROR_IRQ_ENABLE])  // RL10
              | (stat_q[UCF_S_CTS] & ien_q[UCF_S_CTS] & ctrl_q[UCF_B_CTSIEN])  // RL2
              | (stat_q[UCF_S_TC]  & ien_q[UCF_S_TC]);

   ////////////////////////////////////////////////////////////////////////
   // infrared low-power tick: one pulse every divider clocks
   logic [7:0] ir_cnt_q;
   logic       ir_tick_q;
   wire        ir_act = ir_en && ir_lp;                 // RL8 RL9
   wire        ir_wrap = (ir_cnt_q + 8'h01 >= divider); // code 1 -> /1, 2 -> /2
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ir_cnt_q  <= 8'h00;
         ir_tick_q <= 1'b0;
      end else if (!ir_act || divider == 8'h00) begin
         ir_cnt_q  <= 8'h00;                            // reserved code stops
         ir_tick_q <= 1'b0;
      end else if (ir_wrap) begin
         ir_cnt_q  <= 8'h00;                            // RL13 RL14
         ir_tick_q <= 1'b1;
      end else begin
         ir_cnt_q  <= ir_cnt_q + 8'h01;
         ir_tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // card clock: toggles every card_div clocks, so period is 2*card_div
   logic [4:0] sc_cnt_q;
   logic       card_clk_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sc_cnt_q   <= 5'h00;
         card_clk_q <= 1'b0;
      end else if (!sc_en || card_div == 5'h00) begin
         sc_cnt_q   <= 5'h00;                           // RL16 reserved holds low
         card_clk_q <= 1'b0;
      end else if (sc_cnt_q + 5'h01 >= card_div) begin
         sc_cnt_q   <= 5'h00;
         card_clk_q <= ~card_clk_q;                     // RL15
      end else begin
         sc_cnt_q   <= sc_cnt_q + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   logic      txd_q;
   logic      rxd_q;
   logic      nack_q;
   logic      irq_q;
   ucf_mode_t mode_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         txd_q  <= 1'b0;
         rxd_q  <= 1'b0;
         nack_q <= 1'b0;
         irq_q  <= 1'b0;
         mode_q <= '0;
      end else begin
         txd_q  <= ctrl_q[UCF_B_TXDMA] & i_evt.tx_empty;              // RL3
         rxd_q  <= ctrl_q[UCF_B_RXDMA] & i_evt.rx_full;               // RL4
         nack_q <= sc_en & ctrl_q[UCF_B_NACK] & i_evt.parity_err;     // RL6
         irq_q  <= irq_d;
         mode_q.cts_flow     <= ctrl_q[UCF_B_CTS_FLOW_ENABLE];                  // RL2
         mode_q.rts_flow     <= ctrl_q[UCF_B_RTS_FLOW_ENABLE];                  // RL2
         mode_q.smartcard    <= sc_en;                                // RL5
         mode_q.single_wire  <= ctrl_q[UCF_B_SWIRE];                  // RL7
         mode_q.infrared     <= ir_en;                                // RL9
         mode_q.ir_low_power <= ir_en & ir_lp;                        // RL8
      end
   end
   assign o_tx_dma_req  = txd_q;
   assign o_rx_dma_req  = rxd_q;
   assign o_nack_req    = nack_q;
   assign o_irq         = irq_q;
   assign o_mode        = mode_q;
   assign o_tx_complete = tc_q;
   assign o_ir_tick     = ir_tick_q;
   assign o_card_clk    = card_clk_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL1
      $past(i_rd) |-> (o_rdata[31:16] == 16'h0000))
      else $error("reserved bits not zero");
   tx_dma_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL3
      !$past(ctrl_q[UCF_B_TXDMA]) |-> !o_tx_dma_req)
      else $error("tx dma request while disabled");
   rx_dma_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL4
      !$past(ctrl_q[UCF_B_RXDMA]) |-> !o_rx_dma_req)
      else $error("rx dma request while disabled");
   nack_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL6
      o_nack_req |-> $past(sc_en && ctrl_q[UCF_B_NACK] && i_evt.parity_err))
      else $error("nack without cause");
   err_irq_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL10
      (any_err && ctrl_q[UCF_B_ERROR_IRQ_ENABLE] && ien_q[UCF_S_ERR] && !wr_ctrl && !wr_ien)
      |-> ##2 o_irq)
      else $error("error interrupt missing");
   guard_delay_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL11
      (i_evt.tx_char_done && sc_en && guard == 8'h03 && !gt_run_q)
      |-> !o_tx_complete [*4] ##1 (o_tx_complete || i_evt.tx_char_done || gt_run_q))
      else $error("guard time not honoured");
   ir_div_one_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL14
      (ir_act && divider == 8'h01) [*2] |=> o_ir_tick)
      else $error("divide by one not ticking");
   card_div_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL15
      (sc_en && card_div == 5'h01 && !wr_ctrl && !wr_guard_time_and_divider) [*3] |->
      (o_card_clk != $past(o_card_clk)))
      else $error("card clock not divide by two");
   mode_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RL5
      o_mode.smartcard == $past(sc_en))
      else $error("smartcard mode mismatch");

endmodule

//--- tb/ucf_peer.sv
`timescale 1ns/10ps
// stand-in for the frame engine and serial peer: hands the bench's event
// pulses to the block unchanged, so every event lasts exactly one cycle
module ucf_peer
   import ucf_pkg::*;
(
   input  wire ucf_evt_t i_fire,   // events requested by the bench
   output ucf_evt_t      o_evt     // events seen by the block
);
   // no retiming: a registered copy would shift every expected latency
   assign o_evt = i_fire;
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench
   import ucf_pkg::*;
;
   logic        i_clk   = 1'b0;      // 50 MHz clock
   logic        i_nrst  = 1'b0;      // reset, active low
   logic        i_wr    = 1'b0;      // write strobe
   logic        i_rd    = 1'b0;      // read strobe
   logic [3:0]  i_addr  = 4'h0;      // word index
   logic [31:0] i_wdata = 32'h0;     // write data
   logic [31:0] seed_q  = 32'h5e7cfee4; // xorshift state
   logic [31:0] rdata;               // read data
   logic [31:0] v;                   // scratch value
   ucf_evt_t    fire    = '0;        // events asked of the peer
   ucf_evt_t    evt;                 // events into the block
   ucf_mode_t   mode;                // decoded modes
   logic        txd, rxd, nack, tc, tick, cclk, irq;
   logic [7:0]  evs [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h80}; // irq events
   int          err_total = 0, checks_done = 0, cyc = 0, k, n, g;

   ucf_peer peer (.i_fire(fire), .o_evt(evt));
   ucf_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_evt(evt), .o_rdata(rdata), .o_mode(mode),
      .o_tx_dma_req(txd), .o_rx_dma_req(rxd), .o_nack_req(nack), .o_tx_complete(tc),
      .o_ir_tick(tick), .o_card_clk(cclk), .o_irq(irq));

   always #10 i_clk = ~i_clk;

   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed_q ^= seed_q << 13;
      seed_q ^= seed_q >> 17;
      seed_q ^= seed_q << 5;
      return seed_q;
   endfunction
   // expected mode outputs; low power only counts while infrared is on
   function automatic ucf_mode_t mode_of(logic [10:0] c);
      return '{c[9], c[8], c[5], c[3], c[1], c[1] & c[2]};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(string nm, logic [3:0] a, logic [31:0] e);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   task automatic pulse(logic [7:0] e);
      @(posedge i_clk);
      fire <= ucf_evt_t'(e);
      @(posedge i_clk);
      fire <= '0;
      #1;
   endtask
   task automatic step();
      @(posedge i_clk);
      #1;
   endtask
   // counts tick pulses, or card clock changes, over len cycles
   task automatic cnt(input bit card, input int len, output int c);
      logic p;
      c = 0;
      p = cclk;
      repeat (len) begin
         step();
         if (card ? (cclk !== p) : (tick === 1'b1)) c++;
         p = cclk;
      end
   endtask
   task automatic done(string nm);
      $display("test %s done", nm);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd("ctrl reset", UCF_ADDR_CTRL3, 32'h0);
      rd("guard_time_and_divider reset", UCF_ADDR_GUARD_TIME_AND_DIVIDER, 32'h0);
      chk("mode reset", 32'h0, mode);
      done("reset");
      // first pass writes all ones so every reserved bit is tried
      for (k = 0; k < 8; k++) begin
         v = (k == 0) ? 32'hffffffff : rnd();
         wr(UCF_ADDR_CTRL3, v);
         step();
         chk("mode", mode_of(v[10:0]), mode);
         rd("ctrl", UCF_ADDR_CTRL3, v & 32'h7ff);
         wr(UCF_ADDR_GUARD_TIME_AND_DIVIDER, v | 32'h1);
         rd("guard_time_and_divider", UCF_ADDR_GUARD_TIME_AND_DIVIDER, (v | 32'h1) & 32'hffff);
      end
      rd("unmapped", 4'h9, 32'h0);
      done("registers");
      // requests follow the enables, both ways
      for (k = 0; k < 2; k++) begin
         wr(UCF_ADDR_CTRL3, (k == 1) ? 32'hf0 : 32'h20);
         pulse(8'h13);
         chk("tx dma", k, txd);
         chk("rx dma", k, rxd);
         chk("nack", k, nack);
      end
      done("dma nack");
      // three error kinds, cts change, then the error masked off
      wr(UCF_ADDR_IEN, 32'h7);
      wr(UCF_ADDR_CTRL3, 32'h401);
      for (k = 0; k < 5; k++) begin
         if (k == 4) wr(UCF_ADDR_CTRL3, 32'h0);
         pulse(evs[k]);
         step();
         chk("irq", k < 4, irq);
         rd("status", UCF_ADDR_STAT, (k == 3) ? 32'h2 : 32'h1);
         wr(UCF_ADDR_CLR, 32'h7);
         step();
         chk("irq cleared", 32'h0, irq);
      end
      done("interrupts");
      // guard of zero, one, three and a random length
      wr(UCF_ADDR_CTRL3, 32'h20);
      for (k = 0; k < 4; k++) begin
         g = (k < 2) ? k : (k == 2) ? 3 : (rnd() % 40) + 2;
         wr(UCF_ADDR_GUARD_TIME_AND_DIVIDER, {16'h0, g[7:0], 8'h01});
         pulse(8'h04);
         n = 0;
         while (tc !== 1'b1 && n < 300) begin
            step();
            n++;
         end
         chk("guard", g, n);
      end
      done("guard");
      wr(UCF_ADDR_CTRL3, 32'h6);
      for (k = 0; k < 3; k++) begin
         g = (k < 2) ? k + 1 : (rnd() % 7) + 3;
         wr(UCF_ADDR_GUARD_TIME_AND_DIVIDER, g);
         repeat (3) step();
         cnt(1'b0, 10 * g, n);
         chk("ir ticks", 32'd10, n);
      end
      wr(UCF_ADDR_CTRL3, 32'h2);
      wr(UCF_ADDR_GUARD_TIME_AND_DIVIDER, 32'h1);
      cnt(1'b0, 20, n);
      chk("ir ticks normal", 32'h0, n);
      done("infrared");
      // upper divider bits are random and must be ignored
      wr(UCF_ADDR_CTRL3, 32'h20);
      for (k = 0; k < 3; k++) begin
         g = (k == 0) ? 1 : (rnd() % 31) + 1;
         v = rnd();
         wr(UCF_ADDR_GUARD_TIME_AND_DIVIDER, {24'h0, v[7:5], g[4:0]});
         repeat (70) step();
         cnt(1'b1, 10 * g, n);
         chk("card toggles", 32'd10, n);
      end
      done("card clock");
      wrap_up();
   end
endmodule
